// *** logic/atcr_pkg.sv ***
`default_nettype none
package atcr_pkg;
  // =====================================================
  // Register map
  localparam logic [7:0] TASK_CTRL_OFFSET = 8'h00;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // =====================================================
  // Field positions
  localparam int LAUNCH_BIT = 0;
  localparam int FINISHED_BIT = 1;
  localparam int QUIESCENT_BIT = 2;
  localparam int ACCEPT_BIT = 3;
  localparam int RERUN_BIT = 7;

  // =====================================================
  // Constant readback for the free-running protocol
  localparam logic [31:0] FREE_RUN_VALUE = 32'h0000_0006;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // =====================================================
  // Task protocols
  typedef enum logic {
    ATCR_PROTO_FREE_RUN,
    ATCR_PROTO_LITE
  } atcr_proto_t;

  // Host register request as one carrier
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
  } atcr_req_t;

  // Core-side handshake status as one carrier
  typedef struct packed {
    logic finished;
    logic quiescent;
    logic accept;
  } atcr_core_t;
endpackage
`default_nettype wire

// *** logic/atcr_launch_ctl.sv ***
`default_nettype none
module atcr_launch_ctl (
  input wire logic clk_i,                  // Clock
  input wire logic rst_i,                  // Async reset, active high
  input wire logic lite_mode_i,            // High in lite-bus protocol
  input wire logic set_launch_i,           // Host wrote launch one
  input wire logic rerun_i,                // Automatic re-run setting
  input wire logic finish_i,               // Core reports completion
  input wire logic accept_i,               // Core can take a launch
  input wire logic rd_ctrl_i,              // Host read of control word
  output logic launch_o,                   // Launch bit
  output logic finished_o                  // Sticky finished flag
);
  // =====================================================
  // Launch and finished state
  logic launch_r, launch_nxt;
  logic fin_r, fin_nxt;

  // Next-state: set wins over clear on both bits
  always_comb begin
    launch_nxt = launch_r;
    fin_nxt = fin_r;
    if (launch_r && accept_i) begin
      launch_nxt = 1'b0;                   // [R4]
    end
    if (set_launch_i) begin
      launch_nxt = 1'b1;                   // [R4]
    end
    if (finish_i && rerun_i) begin
      launch_nxt = 1'b1;                   // Re-arm for next task [R8]
    end
    if (rd_ctrl_i) begin
      fin_nxt = 1'b0;                      // [R5] [R12]
    end
    if (finish_i) begin
      fin_nxt = 1'b1;                      // Completion beats the read [R12]
    end
    if (!lite_mode_i) begin
      launch_nxt = 1'b0;
      fin_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      launch_r <= 1'b0;
      fin_r <= 1'b0;
    end else begin
      launch_r <= launch_nxt;
      fin_r <= fin_nxt;
    end
  end

  assign launch_o = launch_r;
  assign finished_o = fin_r;
endmodule
`default_nettype wire

// *** logic/atcr_top.sv ***
`default_nettype none
// What this block does
// R1 - The task-control register sits at byte offset zero.
// R2 - In free-running protocol the register reads the constant 0x6 and never changes.
// R3 - In free-running protocol the core runs from reset, paced only by its data handshakes.
// R4 - Bit 0 is the launch bit, set by the host and cleared by the device on start handshake.
// R5 - Bit 1 is a read-only finished flag set on completion and cleared by a host read.
// R6 - Bit 2 is a read-only flag showing the core is quiescent.
// R7 - Bit 3 is a read-only flag showing the core can accept a launch.
// R8 - Bit 7 is a writable re-run setting and all other bits are reserved.
// R9 - Control may be reached over a memory-mapped lite register port.
// R10 - Arguments map only onto slave register or stream ports, never a master port.
// R11 - Each slave-mapped argument has a fixed offset and fixed width.
// R12 - The finished flag holds from completion until the first following host read.
// R13 - The host launches only while accept reads one, then polls finished.
module atcr_top #(
  parameter atcr_pkg::atcr_proto_t PROTO = atcr_pkg::ATCR_PROTO_LITE
) (
  input wire logic clk_i,                       // 100 MHz clock
  input wire logic rst_i,                       // Async reset, active high
  input wire atcr_pkg::atcr_req_t req_i,        // Host register request
  input wire atcr_pkg::atcr_core_t core_i,      // Core handshake status
  output logic [31:0] rdata_o,                  // Read data, one cycle later
  output logic rvalid_o,                        // Read data valid pulse
  output logic core_start_o,                    // Start to the core
  output logic core_run_o                       // Free-running enable
);
  // =====================================================
  // Decode
  logic lite_mode;
  logic hit;
  logic set_launch;
  logic rd_ctrl;
  logic launch;
  logic finished;
  logic rerun_r, rerun_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic start_r, start_nxt;
  logic run_r, run_nxt;

  // Only one register; other offsets read zero and ignore writes
  assign lite_mode = (PROTO == atcr_pkg::ATCR_PROTO_LITE);
  // One slave register at a fixed offset and width; no master port exists here
  assign hit = (req_i.addr == atcr_pkg::TASK_CTRL_OFFSET); // [R1] [R9] [R10] [R11]
  assign rd_ctrl = req_i.rd && hit && lite_mode;
  assign set_launch = req_i.wr && hit && req_i.wstrb[0] && lite_mode
                      && req_i.wdata[atcr_pkg::LAUNCH_BIT];      // [R4]

  // =====================================================
  // Launch and finished bits
  atcr_launch_ctl u_launch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lite_mode_i(lite_mode),
    .set_launch_i(set_launch),
    .rerun_i(rerun_r),
    .finish_i(core_i.finished),
    .accept_i(core_i.accept),
    .rd_ctrl_i(rd_ctrl),
    .launch_o(launch),
    .finished_o(finished)
  );

  // =====================================================
  // Re-run setting, read path and core drives
  always_comb begin
    rerun_nxt = rerun_r;
    if (req_i.wr && hit && req_i.wstrb[0] && lite_mode) begin
      rerun_nxt = req_i.wdata[atcr_pkg::RERUN_BIT];              // [R8]
    end
    rdata_nxt = atcr_pkg::ZERO_WORD;
    if (req_i.rd && hit) begin
      if (lite_mode) begin
        // Reserved bits stay zero [R8]
        rdata_nxt[atcr_pkg::LAUNCH_BIT] = launch;                 // [R4]
        rdata_nxt[atcr_pkg::FINISHED_BIT] = finished;             // [R5]
        rdata_nxt[atcr_pkg::QUIESCENT_BIT] = core_i.quiescent;    // [R6]
        rdata_nxt[atcr_pkg::ACCEPT_BIT] = core_i.accept;          // [R7]
        rdata_nxt[atcr_pkg::RERUN_BIT] = rerun_r;                 // [R8]
      end else begin
        rdata_nxt = atcr_pkg::FREE_RUN_VALUE;                     // [R2]
      end
    end
    rvalid_nxt = req_i.rd;
    // Start registers the pending or freshly set launch; it drops one cycle after the launch bit clears on accept
    start_nxt = lite_mode && (launch_nxt_view(launch, set_launch));
    run_nxt = !lite_mode;                                         // [R3]
  end

  // Launch as seen next cycle: pending or freshly set
  function automatic logic launch_nxt_view(input logic cur, input logic set);
    launch_nxt_view = cur || set;
  endfunction

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rerun_r <= 1'b0;
      rdata_r <= atcr_pkg::ZERO_WORD;
      rvalid_r <= 1'b0;
      start_r <= 1'b0;
      run_r <= 1'b0;
    end else begin
      rerun_r <= rerun_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      start_r <= start_nxt;
      run_r <= run_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign rvalid_o = rvalid_r;
  assign core_start_o = start_r;
  assign core_run_o = run_r;
endmodule
`default_nettype wire

// *** test/atcr_checker.sv ***
`default_nettype none
module atcr_checker #(
  parameter atcr_pkg::atcr_proto_t PROTO = atcr_pkg::ATCR_PROTO_LITE
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire atcr_pkg::atcr_req_t req_i, // Request
  input wire atcr_pkg::atcr_core_t core_i, // Core status
  input wire logic [31:0] rdata_o, // Read data
  input wire logic rvalid_o, // Read valid
  input wire logic core_start_o, // Start
  input wire logic core_run_o // Run
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Decoded requests; a finish pulse beside a read would mask the clear
  localparam bit LT = PROTO == atcr_pkg::ATCR_PROTO_LITE;
  wire logic rd0 = req_i.rd && req_i.addr == 8'h00 && !core_i.finished;
  wire logic go = req_i.wr && req_i.addr == 8'h00 && req_i.wstrb[0] && req_i.wdata[0];
  wire logic a0 = req_i.addr == 8'h00;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_read_answer: assert property (rvalid_o == $past(req_i.rd))
    else $error("bad rvalid");
  a_free_const: assert property (!LT && rvalid_o && $past(a0) |-> rdata_o == 32'h00000006)
    else $error("bad constant");
  a_run_level: assert property (!$past(rst_i) |-> core_run_o == !LT)
    else $error("bad run");
  a_reserved_zero: assert property (LT && rvalid_o |-> rdata_o[31:8] == 24'h0 && !rdata_o[6:4])
    else $error("reserved set");
  a_live_flags: assert property (LT && rvalid_o && $past(a0)
    |-> rdata_o[3:2] == $past({core_i.accept, core_i.quiescent}))
    else $error("bad flags");
  a_launch_set: assert property (LT && go |=> core_start_o)
    else $error("no start");
  a_launch_clear: assert property (LT && core_start_o && core_i.accept && !go && !core_i.finished
    |-> ##[1:2] !core_start_o)
    else $error("start stuck");
  a_finish_read: assert property (LT && core_i.finished ##1 !req_i.rd ##1 rd0 |=> rdata_o[1])
    else $error("finish lost");
  a_read_clears: assert property (LT && rd0 ##1 rd0 |=> !rdata_o[1])
    else $error("finish kept");
  c_launch: cover property (LT && go);
  c_finish: cover property (LT && core_i.finished);
  c_clear: cover property (LT && rd0 ##1 rd0);
endmodule
bind atcr_top atcr_checker #(.PROTO(PROTO)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .core_i(core_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .core_start_o(core_start_o), .core_run_o(core_run_o));
`default_nettype wire

// *** test/atcr_core_model.sv ***
`default_nettype none
module atcr_core_model (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic start_i, // Start from block
  input wire logic slow_i, // Long task
  output var atcr_pkg::atcr_core_t core_o // Status
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  // ====
  // Task countdown; starts are ignored while busy, like a real core
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) cnt <= 4'h0;
    else if (cnt == 4'h0 && start_i) cnt <= slow_i ? 4'hC : 4'h3;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  end
  // Finish is a one-cycle pulse at the end of the count
  assign core_o = '{cnt == 4'h1, cnt == 4'h0, cnt == 4'h0};
endmodule
`default_nettype wire

// *** test/accel_task_control_register_test.sv ***
`default_nettype none
module accel_task_control_register_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic slow = 1'b0;
  atcr_pkg::atcr_req_t req = '0;
  atcr_pkg::atcr_core_t core;
  logic [31:0] rdata, rdata_f, got, got_f;
  logic rvalid, start, run_l, run_f;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  // ====
  // Core model and both protocol variants on one request stream
  atcr_core_model core_m (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .slow_i(slow),
    .core_o(core));
  atcr_top dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .core_i(core), .rdata_o(rdata),
    .rvalid_o(rvalid), .core_start_o(start), .core_run_o(run_l));
  atcr_top #(.PROTO(atcr_pkg::ATCR_PROTO_FREE_RUN)) dut_f (.clk_i(clk_i), .rst_i(rst_i),
    .req_i(req), .core_i(core), .rdata_o(rdata_f), .rvalid_o(), .core_start_o(),
    .core_run_o(run_f));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bus cycles; an idle edge after each keeps one driver per time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req = '{1'b1, 1'b0, a, d, 4'hF};
    @(posedge clk_i);
    #1 req = '0;
    @(posedge clk_i);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input int n);
    req = '{1'b0, 1'b1, a, 32'h0, 4'h0};
    repeat (n) begin
      @(posedge clk_i);
      #1 got = rdata;
      got_f = rdata_f;
      chk({31'h0, rvalid}, 32'h1);
    end
    req = '0;
    @(posedge clk_i);
    #1;
  endtask
  task automatic t_fields();
    rd(8'h00, 1);
    chk(got, 32'h0000000C);
    chk({run_l, run_f}, 32'h1);
    wr(8'h00, 32'hFFFFFF70);
    rd(8'h00, 1);
    chk(got, 32'h0000000C);
    chk(got_f, 32'h00000006);
    wr(8'h00, 32'h00000080);
    wr(8'h04, 32'h00000081);
    rd(8'h04, 1);
    chk(got, 32'h0);
    rd(8'h00, 1);
    chk(got, 32'h0000008C);
    wr(8'h00, 32'h0);
  endtask
  // Launch, poll for finish, then a back-to-back read must see it gone
  task automatic t_launch(input logic s);
    slow = s;
    rd(8'h00, 1);
    chk(got, 32'h0000000C);
    wr(8'h00, 32'h00000001);
    got = '0;
    for (int i = 0; i < 30 && got[1] !== 1'b1; i++) begin
      rd(8'h00, 1);
      if (s && i == 1) chk(got, 32'h0);
    end
    chk(got, 32'h0000000E);
    rd(8'h00, 2);
    chk(got, 32'h0000000C);
    chk({31'h0, start}, 32'h0);
    chk(got_f, 32'h00000006);
  endtask
  // Re-run set: completion re-arms launch, so start comes back by itself
  task automatic t_rerun();
    slow = 1'b0;
    wr(8'h00, 32'h00000081);
    repeat (4) @(posedge clk_i);
    #1;
    chk({31'h0, start}, 32'h1);
    wr(8'h00, 32'h0);
    repeat (3) @(posedge clk_i);
    #1;
    rd(8'h00, 1);
    chk(got, 32'h0000000E);
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    repeat (5) @(posedge clk_i);
    #1 rst_i = 1'b0;
    t_fields();
    t_launch(1'b0);
    t_launch(1'b1);
    t_rerun();
    wrap_up();
  end
endmodule
`default_nettype wire
